// ---- src/audio_front.sv ----
// Purpose: Audio front end: input redundancy, clock reference, word clock
//          out, outgoing channel status, monitor pair, APB registers
// Assumes: One 20 MHz clock; receivers 0..1 multichannel, the rest stereo
// Notes:   Slow times are parameters so a simulation can shorten them
`timescale 1ns/1ps
module audio_front
#(
  parameter int          NUM_STEREO      = 4,
  parameter int          NUM_CH          = 72,
  parameter int          BLINK_CYCLES    = fe_pkg::BLINK_CYC,
  parameter int          FAILOVER_CYCLES = fe_pkg::FAILOVER_CYC,
  parameter logic [31:0] ORIGIN_CODE     = 32'h5846_4531 // arbitrary
)
(
  // Clock and reset
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  // APB slave
  input  wire logic [7:0]                    paddr,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [31:0]                   pwdata,
  output wire logic [31:0]                   prdata,
  output wire logic                          pready,
  output wire logic                          pslverr,
  // Receiver flags, 0..1 multichannel, then stereo 1..N
  input  wire logic [NUM_STEREO+1:0]         rx_lock,
  input  wire logic [NUM_STEREO+1:0]         rx_known,
  input  wire logic [NUM_STEREO+1:0][2:0]    rx_rate,
  // Word clock
  input  wire logic                          wc_in,
  output wire logic                          wc_out,
  // Reception and monitor
  output wire logic                          multi_sel,
  output wire logic [6:0]                    mon_left,
  output wire logic [6:0]                    mon_right,
  // Outgoing status
  output wire fe_pkg::rate_e                 op_rate,
  output wire logic [31:0]                   cs_status,
  output wire logic [31:0]                   cs_origin,
  // Indicators
  output wire logic [1:0]                    led_multi,
  output wire logic                          led_wc,
  output wire logic                          led_ref
);
  import fe_pkg::*;

  localparam int NRX = NUM_STEREO + 2;

  // Values the logic cannot serve
  if (NUM_STEREO < 1 || NUM_STEREO > 6)
    $error("NUM_STEREO must be 1 to 6");
  if (NUM_CH < 2 || NUM_CH > 128)
    $error("NUM_CH must be 2 to 128");
  if (BLINK_CYCLES < 2 || FAILOVER_CYCLES < 2 ||
      BLINK_CYCLES >= 2**CNT_W || FAILOVER_CYCLES >= 2**CNT_W)
    $error("Blink or failover count out of range");

  typedef struct packed
  {
    ctrl_s            ctrl;
    logic [6:0]       slot;
    logic             active;
    logic [CNT_W-1:0] fail_cnt;
    logic [CNT_W-1:0] blink_cnt;
    logic             blink;
    logic             wc1;
    logic             wc2;
    logic             wc3;
    logic             wc_st;
    logic [PER_W-1:0] per;
    logic [3:0]       wc_prev;
    logic             wc_valid;
    rate_e            wc_rate;
    rate_e            op_rate;
    logic [31:0]      acc;
    logic [31:0]      csw;
    logic [31:0]      origin;
    logic [31:0]      prdata;
    logic             pready;
    logic             pslverr;
    logic [6:0]       mon_l;
    logic [6:0]       mon_r;
    logic [1:0]       led_multi;
    logic             led_wc;
    logic             led_ref;
  } state_s;

  state_s         s_q;
  state_s         s_d;
  logic [NRX-1:0] rx_v;
  rate_e          rx_r [NRX];
  rate_e          low_rate;
  rate_e          mrate;
  rate_e          srate;
  logic           ref_ok;
  logic           wc_rise;
  logic           wc_ref;
  logic           setup;
  logic           wr;
  logic           wr_ctrl;
  logic           fail_hit;
  logic           hit;
  logic [31:0]    rd_data;
  stat_s          stat;

  // Per-input qualifiers
  qual_if qi [NRX] ();
  for (genvar g = 0; g < NRX; g++)
  begin : g_rx
    rx_qualifier u_q
    (
      .pclk      (pclk),
      .presetn   (presetn),
      .lock_raw  (rx_lock[g]),
      .known_raw (rx_known[g]),
      .rate_raw  (rx_rate[g]),
      .q         (qi[g])
    );
    assign rx_v[g] = qi[g].valid;
    assign rx_r[g] = qi[g].rate;
  end

  // Bus phase decode; zero wait states
  assign setup   = psel & ~penable;
  assign wr      = psel & penable & s_q.pready & pwrite;
  assign wr_ctrl = wr && paddr == ADDR_CTRL;

  assign fail_hit = !rx_v[s_q.active] && rx_v[!s_q.active] &&
                    s_q.fail_cnt == CNT_W'(FAILOVER_CYCLES - 1);

  // Word clock rising edge once stages two and three agree
  assign wc_rise = s_q.wc2 == s_q.wc3 && s_q.wc3 && !s_q.wc_st;
  assign wc_ref  = s_q.ctrl.clk_src == SRC_WORD;

  always_comb
  begin
    low_rate = R48;
    for (int i = NRX - 1; i >= 2; i--)
      if (rx_v[i])
        low_rate = rx_r[i];
  end

  always_comb
  begin
    if (s_q.ctrl.quadruple_rate_range)
      mrate = (s_q.ctrl.clk_src == SRC_INT44) ? R176 : R192;
    else if (s_q.ctrl.double_rate_range)
      mrate = (s_q.ctrl.clk_src == SRC_INT44) ? R88 : R96;
    else
      mrate = (s_q.ctrl.clk_src == SRC_INT44) ? R44 : R48;
  end

  always_comb
  begin
    case (s_q.ctrl.clk_src)
      SRC_STEREO:
      begin
        ref_ok = |rx_v[NRX-1:2];
        srate  = low_rate;
      end
      SRC_MULTI:
      begin
        ref_ok = rx_v[s_q.active];
        srate  = rx_r[s_q.active];
      end
      SRC_WORD:
      begin
        ref_ok = s_q.wc_valid;
        srate  = s_q.wc_rate;
      end
      default:
      begin
        ref_ok = 1'h1;
        srate  = mrate;
      end
    endcase
  end

  // Register read view; reserved bits read zero
  always_comb
  begin
    stat              = '0;
    stat.ref_ok       = ref_ok;
    stat.op_rate      = s_q.op_rate;
    stat.on_backup    = s_q.active != s_q.ctrl.multi_pref;
    stat.multi_active = s_q.active;
    stat.wc_valid     = s_q.wc_valid;
    stat.rx_valid     = 8'(rx_v);
    hit               = 1'h1;
    case (paddr)
      ADDR_CTRL: rd_data = s_q.ctrl;
      ADDR_MON:  rd_data = {25'h0, s_q.slot};
      ADDR_STAT: rd_data = stat;
      ADDR_CSW:  rd_data = s_q.csw;
      ADDR_ORG:  rd_data = s_q.origin;
      default:
      begin
        rd_data = 32'h0;
        hit     = 1'h0;
      end
    endcase
  end

  // Next state of the whole block
  always_comb
  begin
    s_d = s_q;

    // APB answer in the cycle after setup
    s_d.pready  = setup;
    s_d.pslverr = setup & ~hit;
    if (setup)
      s_d.prdata = rd_data;

    if (fail_hit)
    begin
      s_d.active   = !s_q.active;
      s_d.fail_cnt = '0;
    end
    else if (!rx_v[s_q.active] && rx_v[!s_q.active])
      s_d.fail_cnt = s_q.fail_cnt + CNT_W'(1);
    else
      s_d.fail_cnt = '0;

    // Register writes; a new preference takes over reception
    if (wr_ctrl)
    begin
      s_d.ctrl      = ctrl_s'(pwdata);
      s_d.ctrl.rsvd = '0;
      s_d.active    = s_d.ctrl.multi_pref;
      s_d.fail_cnt  = '0;
    end
    // slot only via its register
    // Widened compare so a full 128-channel range still accepts writes
    if (wr && paddr == ADDR_MON && {1'h0, pwdata[6:0]} < 8'(NUM_CH))
      s_d.slot = pwdata[6:0];

    // Shared blink phase
    if (s_q.blink_cnt == CNT_W'(BLINK_CYCLES - 1))
    begin
      s_d.blink_cnt = '0;
      s_d.blink     = !s_q.blink;
    end
    else
      s_d.blink_cnt = s_q.blink_cnt + CNT_W'(1);

    // Word clock input: sync, period measure, rate class
    s_d.wc1 = wc_in;
    s_d.wc2 = s_q.wc1;
    s_d.wc3 = s_q.wc2;
    if (s_q.wc2 == s_q.wc3)
      s_d.wc_st = s_q.wc3;
    if (wc_rise)
    begin
      s_d.per      = PER_W'(1);
      s_d.wc_prev  = (s_q.per == PER_W'(WC_TIMEOUT)) ? 4'h0
                                                     : wc_class(s_q.per);
      s_d.wc_valid = s_d.wc_prev[3] && s_d.wc_prev == s_q.wc_prev;
      if (s_d.wc_valid)
        s_d.wc_rate = rate_e'(s_d.wc_prev[2:0]);
    end
    else if (s_q.per != PER_W'(WC_TIMEOUT))
      s_d.per = s_q.per + PER_W'(1);
    else
    begin
      s_d.wc_valid = 1'h0;
      s_d.wc_prev  = 4'h0;
    end

    if (ref_ok)
      s_d.op_rate = srate;

    if (wc_ref && s_q.wc_valid && wc_rise)
      s_d.acc = 32'h8000_0000;
    else
      s_d.acc = s_q.acc + nco_inc(s_q.op_rate);

    s_d.csw    = cs_word(s_q.op_rate);
    s_d.origin = ORIGIN_CODE;

    s_d.mon_l = s_q.slot;
    s_d.mon_r = (s_q.slot == 7'(NUM_CH - 1)) ? 7'h00 : s_q.slot + 7'h01;

    for (int i = 0; i < 2; i++)
      s_d.led_multi[i] = (1'(i) == s_q.active) ? 1'h1 :
                         (1'(i) == s_q.ctrl.multi_pref) ? s_q.blink : 1'h0;
    s_d.led_wc  = s_q.wc_valid | s_q.blink;
    s_d.led_ref = ref_ok | s_q.blink;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_q      <= '0;
      s_q.ctrl <= ctrl_s'(CTRL_RST);
      s_q.slot <= SLOT_RST;
    end
    else
      s_q <= s_d;
  end

  // Outputs straight from state
  assign prdata    = s_q.prdata;
  assign pready    = s_q.pready;
  assign pslverr   = s_q.pslverr;
  assign wc_out    = s_q.acc[31];
  assign multi_sel = s_q.active;
  assign mon_left  = s_q.mon_l;
  assign mon_right = s_q.mon_r;
  assign op_rate   = s_q.op_rate;
  assign cs_status = s_q.csw;
  assign cs_origin = s_q.origin;
  assign led_multi = s_q.led_multi;
  assign led_wc    = s_q.led_wc;
  assign led_ref   = s_q.led_ref;

  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Sampled reset in antecedents: outputs lag the release edge
  property p_mon_pair;
    presetn && s_q.slot != 7'(NUM_CH - 1) |=> mon_right == mon_left + 7'h01;
  endproperty
  a_mon_pair: assert property (p_mon_pair)
    else $error("monitor right is not next channel");

  property p_mon_keep;
    wr_ctrl |=> $stable(s_q.slot) ##1 mon_left == $past(s_q.slot, 2);
  endproperty
  a_mon_keep: assert property (p_mon_keep)
    else $error("control write moved monitor pair");

  property p_failover;
    fail_hit && !wr_ctrl |=> s_q.active != $past(s_q.active) ##1
                             multi_sel != $past(multi_sel, 2);
  endproperty
  a_failover: assert property (p_failover)
    else $error("no changeover at failover expiry");

  property p_led_active;
    presetn && $past(presetn) && $stable(s_q.active)
      |-> led_multi[s_q.active];
  endproperty
  a_led_active: assert property (p_led_active)
    else $error("lamp of input in use not lit");

  property p_low_stereo;
    s_q.ctrl.clk_src == SRC_STEREO && |rx_v[NRX-1:2]
      |=> s_q.op_rate == $past(low_rate);
  endproperty
  a_low_stereo: assert property (p_low_stereo)
    else $error("stereo reference not lowest valid");

  property p_wc_led;
    s_q.wc_valid [*2] |=> led_wc;
  endproperty
  a_wc_led: assert property (p_wc_led)
    else $error("word clock lamp not steady");

  property p_hold;
    !ref_ok |=> $stable(s_q.op_rate);
  endproperty
  a_hold: assert property (p_hold)
    else $error("rate changed without valid reference");

  property p_phase;
    wc_ref && s_q.wc_valid && wc_rise |=> $rose(wc_out) || wc_out;
  endproperty
  a_phase: assert property (p_phase)
    else $error("word clock out not aligned to input");

  property p_master;
    s_q.ctrl.clk_src == SRC_INT44 && !s_q.ctrl.double_rate_range &&
    !s_q.ctrl.quadruple_rate_range |=> op_rate == R44;
  endproperty
  a_master: assert property (p_master)
    else $error("master rate not 44.1 kHz");

  property p_apb;
    setup |=> pready && pslverr == !$past(hit);
  endproperty
  a_apb: assert property (p_apb)
    else $error("APB answer missing or wrong error");

endmodule

// ---- common/fe_pkg.sv ----
// Purpose: Shared types, register layout and timing for the audio front end
// Assumes: 20 MHz APB clock, 32-bit data, byte addresses
// Notes:   All-zero control reset means internal clock at 48 kHz, single range
package fe_pkg;

  // Clock and derived rate
  localparam int     CLK_PERIOD_NS = 50;
  localparam longint CLK_HZ        = 64'd1_000_000_000 / CLK_PERIOD_NS;

  // Slow times in ms, counts derived (longest times round down)
  localparam int BLINK_MS     = 250;
  localparam int FAILOVER_MS  = 500;
  localparam int BLINK_CYC    = BLINK_MS * 1_000_000 / CLK_PERIOD_NS;
  localparam int FAILOVER_CYC = FAILOVER_MS * 1_000_000 / CLK_PERIOD_NS;
  localparam int CNT_W        = 24;

  // Word clock input: no edge for this long means no signal
  localparam int WC_TIMEOUT_NS = 40_000;
  localparam int WC_TIMEOUT    = WC_TIMEOUT_NS / CLK_PERIOD_NS;
  localparam int PER_W         = 10;

  // Sample rates
  typedef enum logic [2:0] {R32, R44, R48, R64, R88, R96, R176, R192} rate_e;
  localparam int RATE_HZ [8] = '{32000, 44100, 48000, 64000,
                                 88200, 96000, 176400, 192000};
  // Least period in cycles that still counts as each rate
  localparam int WC_LIM [8] = '{539, 435, 365, 270, 218, 160, 109, 95};

  // Clock source codes
  typedef enum logic [2:0]
  {
    SRC_INT48, SRC_INT44, SRC_STEREO, SRC_MULTI, SRC_WORD
  } src_e;

  // Register offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_MON  = 8'h04;
  localparam logic [7:0] ADDR_STAT = 8'h08;
  localparam logic [7:0] ADDR_CSW  = 8'h0C;
  localparam logic [7:0] ADDR_ORG  = 8'h10;

  // Control register layout and reset
  typedef struct packed
  {
    logic [24:0] rsvd;
    logic        auto_assign;
    logic        multi_pref;
    logic        quadruple_rate_range;
    logic        double_rate_range;
    src_e        clk_src;
  } ctrl_s;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [6:0]  SLOT_RST = 7'h00;

  // Status register layout
  typedef struct packed
  {
    logic [16:0] rsvd;
    logic        ref_ok;
    rate_e       op_rate;
    logic        on_backup;
    logic        multi_active;
    logic        wc_valid;
    logic [7:0]  rx_valid;
  } stat_s;

  // Channel status fields
  localparam logic       CS_PRO       = 1'h1;
  localparam logic       CS_AUDIO     = 1'h0;
  localparam logic [2:0] CS_EMPH_NONE = 3'h1;
  localparam logic [3:0] CS_MODE_2CH  = 4'h1;
  localparam logic [2:0] CS_AUX_24    = 3'h1;
  localparam logic [2:0] CS_WLEN_24   = 3'h5;
  localparam logic [3:0] CS_FS [8]    = '{4'h1, 4'h2, 4'h3, 4'h4,
                                          4'h5, 4'h6, 4'h7, 4'h8};

  // Bytes 4, 2, 1, 0 of the outgoing status block
  function automatic logic [31:0] cs_word(input rate_e r);
    return {1'h0, CS_FS[r], 3'h0, 2'h0, CS_WLEN_24, CS_AUX_24,
            4'h0, CS_MODE_2CH, 3'h0, CS_EMPH_NONE, CS_AUDIO, CS_PRO};
  endfunction

  // Phase step of the word clock generator per clock
  function automatic logic [31:0] nco_inc(input rate_e r);
    return 32'((longint'(RATE_HZ[r]) << 32) / CLK_HZ);
  endfunction

  // Period to rate: {ok, rate}
  function automatic logic [3:0] wc_class(input logic [PER_W-1:0] per);
    logic [3:0] r;
    r = 4'h0;
    for (int i = 7; i >= 0; i--)
      if (per >= PER_W'(WC_LIM[i]))
        r = {1'h1, 3'(i)};
    return r;
  endfunction

endpackage

// ---- common/qual_if.sv ----
// Purpose: Qualified state of one receiver
// Assumes: Driven by rx_qualifier on pclk
// Notes:   Rate holds its last value while invalid
`timescale 1ns/1ps
interface qual_if;
  import fe_pkg::*;
  logic  valid;
  rate_e rate;
  modport src (output valid, output rate);
  modport dst (input valid, input rate);
endinterface

// ---- src/rx_qualifier.sv ----
// Purpose: Synchronise and qualify one receiver's lock and rate
// Assumes: Raw flags come from another clock domain
// Notes:   Three stages; a change counts once stages two and three agree
`timescale 1ns/1ps
module rx_qualifier
(
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Raw receiver flags
  input  wire logic       lock_raw,
  input  wire logic       known_raw,
  input  wire logic [2:0] rate_raw,
  // Qualified result
  qual_if.src             q
);
  import fe_pkg::*;

  typedef struct packed
  {
    logic [4:0] s1;
    logic [4:0] s2;
    logic [4:0] s3;
    logic       valid;
    rate_e      rate;
  } state_s;

  state_s s_q;
  state_s s_d;

  // Sync chain; rate only moves while locked so it holds over
  always_comb
  begin
    s_d    = s_q;
    s_d.s1 = {lock_raw, known_raw, rate_raw};
    s_d.s2 = s_q.s1;
    s_d.s3 = s_q.s2;
    if (s_q.s2 == s_q.s3)
    begin
      s_d.valid = s_q.s3[4] & s_q.s3[3];
      if (s_q.s3[4] & s_q.s3[3])
        s_d.rate = rate_e'(s_q.s3[2:0]);
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign q.valid = s_q.valid;
  assign q.rate  = s_q.rate;

endmodule

// ---- tb/far_side.sv ----
// Purpose: Far-side sources: receiver flags and a word clock
// Assumes: Settings come from the bench
// Notes:   Word clock stands low while off
`timescale 1ns/1ps
module far_side
#(
  parameter int N = 6
)
(
  // Settings from the bench
  input  wire logic [N-1:0]      on,
  input  wire logic [N-1:0]      known,
  input  wire logic [N-1:0][2:0] rate,
  input  var  int                wc_half,
  // Pins toward the block
  output wire logic [N-1:0]      rx_lock,
  output wire logic [N-1:0]      rx_known,
  output wire logic [N-1:0][2:0] rx_rate,
  output var  logic              wc_in
);
  // single wire, codes 32 to 192 kHz
  assign rx_lock  = on;
  assign rx_known = on & known;
  // A lost wire shows no stale rate
  for (genvar i = 0; i < N; i++)
  begin : g_rate
    assign rx_rate[i] = on[i] ? rate[i] : ~rate[i];
  end

  // Square word clock, still between uses; one process drives it
  always
  begin
    if (wc_half > 0)
      #(wc_half) wc_in = ~wc_in;
    else
      #100 wc_in = 1'b0;
  end
endmodule

// ---- tb/tb_top.sv ----
// Purpose: Self-checking bench for the audio front end
// Assumes: APB master, no wait states expected but none assumed
// Notes:   Blink and failover counts shortened by parameters
`timescale 1ns/1ps
module tb_top;
  import fe_pkg::*;
  localparam int          N   = 6;
  localparam int          NCH = 72;
  localparam int          FO  = 16;
  localparam int          BL  = 8;
  localparam logic [31:0] ORG = 32'h1234_ABCD; // arbitrary

  // Bus, pins and bookkeeping
  logic              pclk      = 1'b0;
  logic              presetn   = 1'b0;
  logic              psel      = 1'b0;
  logic              penable   = 1'b0;
  logic              pwrite    = 1'b0;
  logic [7:0]        paddr     = 8'h00;
  logic [31:0]       pwdata    = 32'h0;
  logic [N-1:0]      on        = '0;
  logic [N-1:0]      kn        = '1;
  logic [N-1:0][2:0] rs        = '0;
  int                wc_half   = 0;
  logic [31:0]       prdata, rd, cs_status, cs_origin;
  logic              pready, pslverr, er, wc_in, wc_out;
  logic              multi_sel, led_wc, led_ref;
  logic [N-1:0]      rx_lock, rx_known;
  logic [N-1:0][2:0] rx_rate;
  logic [6:0]        mon_left, mon_right;
  logic [1:0]        led_multi;
  logic [3:0]        lamps;
  rate_e             op_rate;
  int                n_fail     = 0;
  int                num_checks = 0;
  int                cyc        = 0;
  int                n, p;
  bit                t;
  rate_e             ex [6] = '{R48, R96, R192, R44, R88, R176};

  assign lamps = {led_ref, led_wc, led_multi};

  // Clock
  always #25 pclk = ~pclk;

  far_side #(.N(N)) i_far
  (
    .on       (on),
    .known    (kn),
    .rate     (rs),
    .wc_half  (wc_half),
    .rx_lock  (rx_lock),
    .rx_known (rx_known),
    .rx_rate  (rx_rate),
    .wc_in    (wc_in)
  );

  audio_front #(.NUM_STEREO(N - 2), .NUM_CH(NCH), .BLINK_CYCLES(BL),
                .FAILOVER_CYCLES(FO), .ORIGIN_CODE(ORG)) i_dut
  (
    .pclk      (pclk),
    .presetn   (presetn),
    .paddr     (paddr),
    .psel      (psel),
    .penable   (penable),
    .pwrite    (pwrite),
    .pwdata    (pwdata),
    .prdata    (prdata),
    .pready    (pready),
    .pslverr   (pslverr),
    .rx_lock   (rx_lock),
    .rx_known  (rx_known),
    .rx_rate   (rx_rate),
    .wc_in     (wc_in),
    .wc_out    (wc_out),
    .multi_sel (multi_sel),
    .mon_left  (mon_left),
    .mon_right (mon_right),
    .op_rate   (op_rate),
    .cs_status (cs_status),
    .cs_origin (cs_origin),
    .led_multi (led_multi),
    .led_wc    (led_wc),
    .led_ref   (led_ref)
  );

  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Hang guard, well above the whole run
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      n_fail++;
      stop_test;
    end
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask

  task automatic wt(input int c);
    repeat (c) @(posedge pclk);
  endtask

  // One APB transfer; holds until pready is seen
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the hang guard may end this wait
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask

  // Edges until the next rise of the word clock output
  task automatic rise(output int c);
    logic q;
    c = 0;
    do
    begin
      q = wc_out;
      @(posedge pclk);
      c++;
    end
    while (!(q === 1'b0 && wc_out === 1'b1) && c < 2000);
  endtask

  // Lamp seen both dark and lit within a few blink times
  task automatic tog(input int i, output bit b);
    bit s0, s1;
    s0 = 0;
    s1 = 0;
    repeat (4 * BL)
    begin
      @(posedge pclk);
      s0 |= (lamps[i] === 1'b0);
      s1 |= (lamps[i] === 1'b1);
    end
    b = s0 & s1;
  endtask

  function automatic logic [31:0] exp_cs(input rate_e r);
    return {1'h0, 4'(r) + 4'h1, 5'h00, 3'h5, 3'h1, 4'h0, 4'h1,
            3'h0, 3'h1, 2'h1};
  endfunction

  // Main sequence
  initial
  begin
    wt(20);
    presetn <= 1'b1;
    wt(2);
    rdchk(ADDR_CTRL, CTRL_RST);
    rdchk(ADDR_MON, 32'h0);
    apb(1'b1, ADDR_ORG, 32'h0);
    rdchk(ADDR_ORG, ORG);
    chk(cs_origin, ORG);
    apb(1'b0, 8'h14, 32'h0);
    chk(32'(er), 32'h1);
    chk(rd, 32'h0);
    // Foreign word clock present but not chosen
    wc_half <= 2500;
    for (int i = 0; i < 6; i++)
    begin
      apb(1'b1, ADDR_CTRL, 32'(i / 3) |
          ((i % 3 == 0) ? 32'h0 : 32'h4 << (i % 3)));
      wt(4);
      chk(32'(op_rate), 32'(ex[i]));
      rdchk(ADDR_CSW, exp_cs(ex[i]));
      chk(cs_status, exp_cs(ex[i]));
      rise(n);
      rise(n);
      p = 20_000_000 / RATE_HZ[ex[i]];
      chk(32'(n >= p - 1 && n <= p + 1), 32'h1);
    end
    wc_half <= 0;
    // Monitor pair, wrap and refused slot
    apb(1'b1, ADDR_MON, 32'h5);
    wt(2);
    chk(32'({mon_left, mon_right}), {18'h0, 7'h05, 7'h06});
    apb(1'b1, ADDR_MON, 32'(NCH - 1));
    apb(1'b1, ADDR_MON, 32'(NCH));
    rdchk(ADDR_MON, 32'(NCH - 1));
    apb(1'b1, ADDR_CTRL, 32'h40);
    wt(2);
    chk(32'({mon_left, mon_right}), {18'h0, 7'(NCH - 1), 7'h00});
    rdchk(ADDR_CTRL, 32'h40);
    // Multichannel failover
    rs[0] <= R44;
    rs[1] <= R96;
    on[1:0] <= 2'h3;
    apb(1'b1, ADDR_CTRL, 32'h3);
    wt(8);
    chk(32'(multi_sel), 32'h0);
    chk(32'(op_rate), 32'(R44));
    on[0] <= 1'b0;
    wt(FO + 8);
    chk(32'(multi_sel), 32'h1);
    wt(2);
    chk(32'(op_rate), 32'(R96));
    apb(1'b0, ADDR_STAT, 32'h0);
    chk(32'(rd[10:9]), 32'h3);
    tog(0, t);
    chk(32'(t), 32'h1);
    tog(1, t);
    chk(32'({t, led_multi[1]}), 32'h1);
    // Stereo reference, lowest valid wins
    apb(1'b1, ADDR_CTRL, 32'h2);
    rs[4] <= R88;
    on[4] <= 1'b1;
    wt(8);
    chk(32'(op_rate), 32'(R88));
    chk(32'(led_ref), 32'h1);
    rs[3] <= R64;
    rs[2] <= R32;
    on[3:2] <= 2'h3;
    kn[2] <= 1'b0;
    wt(8);
    chk(32'(op_rate), 32'(R64));
    apb(1'b0, ADDR_STAT, 32'h0);
    chk(32'(rd[7:0]), 32'h1A);
    on[4:2] <= 3'h0;
    wt(8);
    chk(32'(op_rate), 32'(R64));
    tog(3, t);
    chk(32'(t), 32'h1);
    // Word clock reference
    apb(1'b1, ADDR_CTRL, 32'h4);
    wc_half <= 2500;
    wt(600);
    chk(32'(op_rate), 32'(R192));
    tog(2, t);
    chk(32'({t, led_wc}), 32'h1);
    @(posedge wc_in);
    rise(n);
    chk(32'(n >= 3 && n <= 7), 32'h1);
    wc_half <= 10000;
    wt(1500);
    chk(32'(op_rate), 32'(R48));
    wc_half <= 0;
    wt(1200);
    chk(32'(op_rate), 32'(R48));
    tog(2, t);
    chk(32'(t), 32'h1);
    stop_test;
  end
endmodule
